// [inc/dac_ctrl_pkg.sv]
// shared constants for the dual converter front end and its host
package dac_ctrl_pkg;
  // converter data width
  localparam int DATA_W = 10;
  // control byte rides on data port a bits 9..2
  localparam int CTRL_LSB = 2;
  localparam int CTRL_W = 8;
  // control byte bit positions
  localparam int BIT_POWER_DOWN = 7;
  localparam int BIT_CONV_ENABLE = 6;
  localparam int BIT_INTERLEAVE = 5;
  localparam int BIT_REF_DISABLE = 4;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 4;
  // power-up control byte: running, no interleave, internal ref, trim 1000
  localparam logic [7:0] CTRL_RESET = 8'h48;
  // gain trim: code 0 is +0.40 dB, each step 0.05 dB lower (centi-dB)
  localparam int GAIN_TOP_CDB = 40;
  localparam int GAIN_STEP_CDB = 5;
  // standby recovery time and its cycle count at the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS = 3000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fastest conversion rate per channel, in hertz
  localparam int MAX_RATE_HZ = 80_000_000;
  localparam int SYS_RATE_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  // control strobe low time in system cycles
  localparam int STROBE_LOW_CYCLES = 2;
  // host register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_SAMPLE = 4'hC;
  // mode register bits
  localparam int MODE_DIFF_CLK = 0;
  localparam int MODE_EXT_REF = 1;
  localparam int MODE_STREAM = 2;
  // sample register field positions
  localparam int SAMPLE_A_LSB = 0;
  localparam int SAMPLE_B_LSB = 16;
  // status register bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_AWAKE = 1;
  localparam int STAT_FULL = 2;
endpackage

// [inc/dac_link_if.sv]
// pins between the dual converter and its host data source
`timescale 1ns/10ps
interface dac_link_if;
  logic [9:0] data_a;
  logic [9:0] data_b;
  logic control_strobe_n;
  logic diff_clock_select_n;
  logic se_clock_from_host;
  logic se_clock_host_oe;
  logic se_clock_from_dev;
  logic se_clock_dev_oe;
  logic differential_clock_pair_p;
  logic differential_clock_pair_n;
  logic reference_pin_dev;
  logic reference_pin_dev_oe;
  logic reference_pin_host;
  logic reference_pin_host_oe;
  modport dev (
    input data_a, data_b, control_strobe_n, diff_clock_select_n,
    input se_clock_from_host, se_clock_host_oe,
    input differential_clock_pair_p, differential_clock_pair_n,
    input reference_pin_host, reference_pin_host_oe,
    output se_clock_from_dev, se_clock_dev_oe,
    output reference_pin_dev, reference_pin_dev_oe
  );
  modport host (
    output data_a, data_b, control_strobe_n, diff_clock_select_n,
    output se_clock_from_host, se_clock_host_oe,
    output differential_clock_pair_p, differential_clock_pair_n,
    output reference_pin_host, reference_pin_host_oe,
    input se_clock_from_dev, se_clock_dev_oe,
    input reference_pin_dev, reference_pin_dev_oe
  );
endinterface

// [src/dac_front_end.sv]
// converter side: clock mode, input pipeline, control byte and power state
`timescale 1ns/10ps
module dac_front_end #(
  parameter int WAKE_COUNT = dac_ctrl_pkg::WAKE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  dac_link_if.dev link,
  output logic [9:0] o_out_a,
  output logic [9:0] o_out_b,
  output logic o_out_strobe,
  output logic o_power_down,
  output logic o_standby,
  output logic o_outputs_valid,
  output logic o_interleave,
  output logic o_internal_ref,
  output logic [3:0] o_gain_trim_code,
  output logic signed [7:0] o_gain_a_cdb,
  output logic o_ref_conflict
);
  // elaboration guard: the recovery counter is sixteen bits wide
  if (WAKE_COUNT < 1 || WAKE_COUNT > 65535) begin : g_bad_wake
    $error("wake count out of range");
  end

  localparam int W = dac_ctrl_pkg::DATA_W;

  logic [7:0] ctrl;
  logic strobe_prev;
  logic conv_clk;
  logic conv_prev;
  logic [W-1:0] data_a_q;
  logic [W-1:0] data_b_q;
  logic conv_rise;
  logic conv_fall;
  logic running;
  logic [W-1:0] in_a;
  logic [W-1:0] in_b;
  logic [W-1:0] held_b;
  logic [15:0] wake_cnt;
  logic replica;
  logic signed [7:0] next_gain;

  // mode bits decoded from the latched control byte
  assign o_power_down = ctrl[dac_ctrl_pkg::BIT_POWER_DOWN];
  assign o_standby = !ctrl[dac_ctrl_pkg::BIT_POWER_DOWN]
    && !ctrl[dac_ctrl_pkg::BIT_CONV_ENABLE];
  assign running = !o_power_down && !o_standby;
  assign o_interleave = ctrl[dac_ctrl_pkg::BIT_INTERLEAVE];
  assign o_internal_ref = !ctrl[dac_ctrl_pkg::BIT_REF_DISABLE];
  assign o_gain_trim_code = ctrl[dac_ctrl_pkg::GAIN_LSB +: dac_ctrl_pkg::GAIN_W];

  // control byte capture on the strobe's rising edge, clock may keep running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= dac_ctrl_pkg::CTRL_RESET;
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= link.control_strobe_n;
      if (link.control_strobe_n && !strobe_prev) begin
        ctrl <= link.data_a[dac_ctrl_pkg::CTRL_LSB +: dac_ctrl_pkg::CTRL_W];
      end
    end
  end

  // clock source follows the mode select: pin input when high, pair when low
  always_comb begin
    if (link.diff_clock_select_n) begin
      conv_clk = link.se_clock_from_host;
    end else begin
      conv_clk = link.differential_clock_pair_p
        && !link.differential_clock_pair_n;
    end
  end

  // edge detection by sampling; words come from a register one cycle behind the live clock, so a word
  // that changes together with the clock is not taken at that edge, the previous word is
  // limitation: the conversion rate is at most a quarter of i_clk
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_prev <= 1'b0;
      data_a_q <= '0;
      data_b_q <= '0;
    end else begin
      conv_prev <= conv_clk;
      data_a_q <= link.data_a;
      data_b_q <= link.data_b;
    end
  end
  assign conv_rise = conv_clk && !conv_prev;
  assign conv_fall = !conv_clk && conv_prev;

  // replica of the differential clock driven out on the single-ended pin
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      replica <= 1'b0;
    end else begin
      replica <= link.differential_clock_pair_p;
    end
  end
  assign link.se_clock_from_dev = replica;
  assign link.se_clock_dev_oe = !link.diff_clock_select_n;

  // interleaved mode: channel b word rides port a on the falling edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      held_b <= '0;
    end else if (running && o_interleave && conv_fall) begin
      held_b <= data_a_q;
    end
  end

  // input stage: words taken on each rising conversion edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_a <= '0;
      in_b <= '0;
    end else if (running && conv_rise) begin
      in_a <= data_a_q;
      if (o_interleave) begin
        in_b <= held_b;
      end else begin
        in_b <= data_b_q;
      end
    end
  end

  // output stage: previous words move out on the same rising edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_a <= '0;
      o_out_b <= '0;
    end else if (running && conv_rise) begin
      o_out_a <= in_a;
      o_out_b <= in_b;
    end
  end

  // one-cycle mark of each output update
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_strobe <= 1'b0;
    end else begin
      o_out_strobe <= running && conv_rise;
    end
  end

  // recovery count restarts whenever the core is not running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_cnt <= 16'h0000;
      o_outputs_valid <= 1'b1;
    end else if (!running) begin
      wake_cnt <= 16'h0000;
      o_outputs_valid <= 1'b0;
    end else if (!o_outputs_valid) begin
      wake_cnt <= wake_cnt + 16'h0001;
      if (wake_cnt == 16'(WAKE_COUNT - 1)) begin
        o_outputs_valid <= 1'b1;
      end
    end
  end

  // gain of channel a in centi-dB: highest at code 0, lowest at all ones
  always_comb begin
    next_gain = 8'(dac_ctrl_pkg::GAIN_TOP_CDB)
      - 8'(dac_ctrl_pkg::GAIN_STEP_CDB) * signed'({4'h0, o_gain_trim_code});
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gain_a_cdb <= 8'sh00;
    end else begin
      o_gain_a_cdb <= next_gain;
    end
  end

  // reference pin: driven only while the internal reference is on
  assign link.reference_pin_dev = 1'b1;
  assign link.reference_pin_dev_oe = o_internal_ref && !o_power_down;

  // flags both parties driving, or nobody, the reference pin while the core is running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ref_conflict <= 1'b0;
    end else begin
      o_ref_conflict <= (link.reference_pin_dev_oe == link.reference_pin_host_oe)
        && running;
    end
  end
endmodule // dac_front_end

// [src/dac_host_source.sv]
// host side: makes the conversion clock, streams samples, writes control
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module dac_host_source #(
  parameter int HALF_PERIOD = 2,
  parameter int WAKE_COUNT = dac_ctrl_pkg::WAKE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  dac_link_if.host link,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  // edges are found by sampling, so each half period needs two cycles
  if (HALF_PERIOD < 2 || HALF_PERIOD > 255
    || dac_ctrl_pkg::SYS_RATE_HZ / (2 * HALF_PERIOD) > dac_ctrl_pkg::MAX_RATE_HZ) begin : g_bad_half
    $error("half period out of range");
  end
  if (WAKE_COUNT < 1 || WAKE_COUNT > 65535) begin : g_bad_wake
    $error("wake count out of range");
  end

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOW = 2'b01,
    S_HIGH = 2'b11
  } cw_state_t;

  cw_state_t cw_state;
  logic [7:0] div_cnt;
  logic conv_clk;
  logic tick_rise;
  logic tick_fall;
  logic [7:0] ctrl_shadow;
  logic [7:0] ctrl_pending;
  logic [2:0] mode;
  logic [1:0] low_cnt;
  logic [9:0] samp_a;
  logic [9:0] samp_b;
  logic samp_full;
  logic [15:0] wake_cnt;
  logic awake;
  logic rd_ack;
  logic wr_ctrl;
  logic wr_samp;
  logic wr_mode;
  logic stream_on;
  logic stalled;

  // divider: the conversion clock toggles every HALF_PERIOD cycles
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 8'h00;
      conv_clk <= 1'b0;
    end else if (div_cnt == 8'(HALF_PERIOD - 1)) begin
      div_cnt <= 8'h00;
      conv_clk <= !conv_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick_rise = (div_cnt == 8'(HALF_PERIOD - 1)) && !conv_clk;
  assign tick_fall = (div_cnt == 8'(HALF_PERIOD - 1)) && conv_clk;

  // clock onto the pin or the pair as the mode bit says
  assign link.diff_clock_select_n = !mode[dac_ctrl_pkg::MODE_DIFF_CLK];
  assign link.se_clock_from_host = conv_clk;
  assign link.se_clock_host_oe = !mode[dac_ctrl_pkg::MODE_DIFF_CLK];
  assign link.differential_clock_pair_p = conv_clk;
  assign link.differential_clock_pair_n = !conv_clk;
  assign link.reference_pin_host = 1'b1;
  assign link.reference_pin_host_oe = mode[dac_ctrl_pkg::MODE_EXT_REF];

  // bus decode; a busy target stalls the master with waitrequest
  assign wr_ctrl = i_avs_write && i_avs_address == dac_ctrl_pkg::ADDR_CTRL;
  assign wr_mode = i_avs_write && i_avs_address == dac_ctrl_pkg::ADDR_MODE;
  assign wr_samp = i_avs_write && i_avs_address == dac_ctrl_pkg::ADDR_SAMPLE;
  assign stalled = (wr_ctrl && cw_state != S_IDLE) || (wr_samp && samp_full);
  assign o_avs_waitrequest = (i_avs_read && !rd_ack) || stalled;
  assign stream_on = mode[dac_ctrl_pkg::MODE_STREAM] && cw_state == S_IDLE;

  // reads take one wait cycle so read data come from a register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= i_avs_read && !rd_ack;
      unique case (i_avs_address)
        dac_ctrl_pkg::ADDR_CTRL: o_avs_readdata <= {24'h000000, ctrl_shadow};
        dac_ctrl_pkg::ADDR_MODE: o_avs_readdata <= {29'h0, mode};
        dac_ctrl_pkg::ADDR_STATUS: o_avs_readdata <= {29'h0, samp_full, awake,
          cw_state != S_IDLE};
        dac_ctrl_pkg::ADDR_SAMPLE: o_avs_readdata <= {6'h00, samp_b, 6'h00, samp_a};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // mode register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode <= 3'h0;
    end else if (wr_mode) begin
      mode <= i_avs_writedata[2:0];
    end
  end

  // one-word sample holding register, emptied by the link
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_a <= 10'h000;
      samp_b <= 10'h000;
      samp_full <= 1'b0;
    end else if (wr_samp && !samp_full) begin
      samp_a <= i_avs_writedata[dac_ctrl_pkg::SAMPLE_A_LSB +: 10];
      samp_b <= i_avs_writedata[dac_ctrl_pkg::SAMPLE_B_LSB +: 10];
      samp_full <= 1'b1;
    end else if (stream_on && tick_fall) begin
      samp_full <= 1'b0;
    end
  end

  // control byte strobe: low, then a rising edge with the byte held on port a
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cw_state <= S_IDLE;
      low_cnt <= 2'h0;
      ctrl_pending <= dac_ctrl_pkg::CTRL_RESET;
      ctrl_shadow <= dac_ctrl_pkg::CTRL_RESET;
    end else begin
      unique case (cw_state)
        S_IDLE: begin
          low_cnt <= 2'h0;
          if (wr_ctrl) begin
            ctrl_pending <= i_avs_writedata[7:0];
            cw_state <= S_LOW;
          end
        end
        S_LOW: begin
          low_cnt <= low_cnt + 2'h1;
          if (low_cnt == 2'(dac_ctrl_pkg::STROBE_LOW_CYCLES - 1)) begin
            cw_state <= S_HIGH;
          end
        end
        S_HIGH: begin
          ctrl_shadow <= ctrl_pending;
          cw_state <= S_IDLE;
        end
      endcase
    end
  end
  assign link.control_strobe_n = cw_state != S_LOW;

  // data pins: a change half a period before the capturing edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link.data_a <= 10'h000;
      link.data_b <= 10'h000;
    end else if (wr_ctrl && cw_state == S_IDLE) begin
      link.data_a <= {i_avs_writedata[7:0], 2'b00};
    end else if (stream_on && ctrl_shadow[dac_ctrl_pkg::BIT_INTERLEAVE]) begin
      if (tick_rise) begin
        link.data_a <= samp_b;
      end else if (tick_fall) begin
        link.data_a <= samp_a;
      end
    end else if (stream_on && tick_fall) begin
      link.data_a <= samp_a;
      link.data_b <= samp_b;
    end
  end

  // outputs are trusted only after the recovery interval
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_cnt <= 16'h0000;
      awake <= 1'b1;
    end else if (ctrl_shadow[dac_ctrl_pkg::BIT_POWER_DOWN]
      || !ctrl_shadow[dac_ctrl_pkg::BIT_CONV_ENABLE]) begin
      wake_cnt <= 16'h0000;
      awake <= 1'b0;
    end else if (!awake) begin
      wake_cnt <= wake_cnt + 16'h0001;
      if (wake_cnt == 16'(WAKE_COUNT - 1)) begin
        awake <= 1'b1;
      end
    end
  end
endmodule // dac_host_source

// [verification/dac_link_chk.sv]
// concurrent checks on the converter link and the front end status
`timescale 1ns/10ps
module dac_link_chk #(
  parameter int WAKE_COUNT = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [9:0] data_a,
  input wire logic [9:0] data_b,
  input wire logic control_strobe_n,
  input wire logic diff_clock_select_n,
  input wire logic se_clock_from_host,
  input wire logic se_clock_host_oe,
  input wire logic se_clock_from_dev,
  input wire logic se_clock_dev_oe,
  input wire logic differential_clock_pair_p,
  input wire logic differential_clock_pair_n,
  input wire logic reference_pin_dev_oe,
  input wire logic o_power_down,
  input wire logic o_standby,
  input wire logic o_outputs_valid,
  input wire logic o_interleave,
  input wire logic o_internal_ref,
  input wire logic [3:0] o_gain_trim_code,
  input wire logic signed [7:0] o_gain_a_cdb,
  input wire logic [9:0] o_out_a,
  input wire logic [9:0] o_out_b
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic conv_q, strobe_q;
  logic [9:0] fall_a, pair_b, last_a, last_b, exp_a, exp_b, da_q, db_q;
  logic [7:0] cap;
  logic [2:0] n_rise;
  int wake;
  wire conv = diff_clock_select_n ? se_clock_from_host :
    (differential_clock_pair_p & !differential_clock_pair_n);
  wire conv_rise = conv & !conv_q;
  wire running = !o_standby & !o_power_down;
  // expected words; b pairs with the fall before the a rise
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {conv_q, strobe_q, cap} <= '0;
      {fall_a, pair_b, last_a, last_b, exp_a, exp_b, da_q, db_q} <= '0;
    end else begin
      conv_q <= conv;
      da_q <= data_a;
      db_q <= data_b;
      strobe_q <= control_strobe_n;
      if (control_strobe_n && !strobe_q) cap <= data_a[9:2];
      if (!conv && conv_q) fall_a <= da_q;
      if (conv_rise) begin
        pair_b <= fall_a;
        last_a <= da_q;
        last_b <= db_q;
        exp_a <= last_a;
        exp_b <= o_interleave ? pair_b : last_b;
      end
    end
  end
  // settling counts; mode changes and wake-up make early words untrustworthy
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      n_rise <= 3'h0;
      wake <= WAKE_COUNT + 4;
    end else begin
      if (!control_strobe_n || !running) n_rise <= 3'h0;
      else if (conv_rise && n_rise != 3'h4) n_rise <= n_rise + 3'h1;
      if (!running) wake <= 0;
      else if (wake < WAKE_COUNT + 4) wake <= wake + 1;
    end
  end
  sequence s_settled_rise;
    conv_rise && running && n_rise == 3'h4;
  endsequence
  sequence s_strobe_done;
    $rose(control_strobe_n);
  endsequence
  property p_pipe;
    s_settled_rise |-> ##[1:3] (o_out_a == exp_a && o_out_b == exp_b);
  endproperty
  a_pipe: assert property (p_pipe) else $error("output words wrong");
  property p_ctrl;
    s_strobe_done |-> ##2 (o_power_down == cap[7] && o_interleave == cap[5] &&
      o_internal_ref == !cap[4] && o_gain_trim_code == cap[3:0] &&
      o_standby == (!cap[7] && !cap[6]));
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control byte not applied");
  property p_gain;
    o_gain_a_cdb == 8'(40 - 5 * $past(o_gain_trim_code));
  endproperty
  a_gain: assert property (p_gain) else $error("gain trim wrong");
  property p_ref_int;
    (o_internal_ref && !o_power_down)[*2] |-> reference_pin_dev_oe;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("reference not driven");
  property p_ref_ext;
    (!o_internal_ref || o_power_down)[*2] |-> !reference_pin_dev_oe;
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("reference still driven");
  property p_se_mode;
    diff_clock_select_n[*2] |-> se_clock_host_oe && !se_clock_dev_oe;
  endproperty
  a_se_mode: assert property (p_se_mode) else $error("clock pin not input");
  property p_diff_mode;
    (!diff_clock_select_n)[*2] |-> !se_clock_host_oe && se_clock_dev_oe;
  endproperty
  a_diff_mode: assert property (p_diff_mode) else $error("clock pin not output");
  property p_replica;
    (!diff_clock_select_n)[*2] ##0 $rose(differential_clock_pair_p) |-> ##[0:2] se_clock_from_dev;
  endproperty
  a_replica: assert property (p_replica) else $error("replica clock missing");
  property p_wake_hold;
    (wake > 1 && wake < WAKE_COUNT - 2) |-> !o_outputs_valid;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("valid too early");
  property p_wake_done;
    wake == WAKE_COUNT + 3 |-> o_outputs_valid;
  endproperty
  a_wake_done: assert property (p_wake_done) else $error("valid too late");
endmodule // dac_link_chk

// [verification/dual_dac_input_and_mode_control_tb.sv]
// self-checking bench: host bus drives the host end, device end observed
`timescale 1ns/10ps
module dual_dac_input_and_mode_control_tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata, q;
  logic o_avs_waitrequest, o_out_strobe, o_power_down, o_standby, o_outputs_valid;
  logic o_interleave, o_internal_ref, o_ref_conflict;
  logic [9:0] o_out_a, o_out_b;
  logic [3:0] o_gain_trim_code;
  logic signed [7:0] o_gain_a_cdb;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 i_clk = ~i_clk;
  dac_link_if link ();
  dac_front_end #(.WAKE_COUNT(16)) dac_front_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .link(link), .o_out_a(o_out_a), .o_out_b(o_out_b), .o_out_strobe(o_out_strobe),
    .o_power_down(o_power_down), .o_standby(o_standby), .o_outputs_valid(o_outputs_valid),
    .o_interleave(o_interleave), .o_internal_ref(o_internal_ref),
    .o_gain_trim_code(o_gain_trim_code), .o_gain_a_cdb(o_gain_a_cdb),
    .o_ref_conflict(o_ref_conflict));
  dac_host_source #(.HALF_PERIOD(2), .WAKE_COUNT(16)) dac_host_source_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .link(link), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
  dac_link_chk #(.WAKE_COUNT(16)) dac_link_chk_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .data_a(link.data_a), .data_b(link.data_b), .control_strobe_n(link.control_strobe_n),
    .diff_clock_select_n(link.diff_clock_select_n),
    .se_clock_from_host(link.se_clock_from_host), .se_clock_host_oe(link.se_clock_host_oe),
    .se_clock_from_dev(link.se_clock_from_dev), .se_clock_dev_oe(link.se_clock_dev_oe),
    .differential_clock_pair_p(link.differential_clock_pair_p),
    .differential_clock_pair_n(link.differential_clock_pair_n),
    .reference_pin_dev_oe(link.reference_pin_dev_oe), .o_power_down(o_power_down),
    .o_standby(o_standby), .o_outputs_valid(o_outputs_valid), .o_interleave(o_interleave),
    .o_internal_ref(o_internal_ref), .o_gain_trim_code(o_gain_trim_code),
    .o_gain_a_cdb(o_gain_a_cdb), .o_out_a(o_out_a), .o_out_b(o_out_b));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard; the whole run needs a few hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // one bus transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_mismatch++;
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  // control write, wait for strobe idle, then compare every field
  task automatic ctrl(input logic [7:0] b);
    int n;
    bus(1'b1, dac_ctrl_pkg::ADDR_CTRL, {24'h0, b});
    n = 0;
    do begin
      bus(1'b0, dac_ctrl_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (q[dac_ctrl_pkg::STAT_BUSY] !== 1'b0 && n < 20);
    repeat (2) @(posedge i_clk);
    chk("power_down", 32'(b[7]), 32'(o_power_down));
    chk("standby", 32'(!b[7] && !b[6]), 32'(o_standby));
    chk("interleave", 32'(b[5]), 32'(o_interleave));
    chk("internal_ref", 32'(!b[4]), 32'(o_internal_ref));
    chk("gain_code", 32'(b[3:0]), 32'(o_gain_trim_code));
    chk("gain_cdb", 32'(40 - 5 * int'(b[3:0])), 32'(o_gain_a_cdb));
  endtask
  // hand a sample pair to the host and wait for it at the outputs
  task automatic stream(input logic [9:0] a, input logic [9:0] b);
    int n;
    bus(1'b1, dac_ctrl_pkg::ADDR_SAMPLE, {6'h0, b, 6'h0, a});
    n = 0;
    while ((o_out_a !== a || o_out_b !== b) && n < 80) begin
      @(posedge i_clk);
      n++;
    end
    chk("out_a", 32'(a), 32'(o_out_a));
    chk("out_b", 32'(b), 32'(o_out_b));
    chk("out_strobe", 32'h1, 32'(o_out_strobe));
  endtask
  // wake-up after standby or power-down
  task automatic wake();
    int n;
    ctrl(8'h48);
    chk("valid_low", 32'h0, 32'(o_outputs_valid));
    n = 0;
    while (o_outputs_valid !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    bus(1'b0, dac_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk("awake", 32'h1, 32'(q[dac_ctrl_pkg::STAT_AWAKE]));
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("ctrl_default", 32'h48, 32'({o_power_down, !o_standby, o_interleave,
      !o_internal_ref, o_gain_trim_code}));
    chk("valid_default", 32'h1, 32'(o_outputs_valid));
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test defaults done");
    bus(1'b1, dac_ctrl_pkg::ADDR_MODE, 32'h4);
    stream(10'h155, 10'h2AA);
    stream(10'h3FF, 10'h000);
    $display("test single-ended stream done");
    ctrl(8'h68);
    stream(10'h123, 10'h321);
    stream(10'h2C4, 10'h0F0);
    ctrl(8'h4F);
    ctrl(8'h40);
    $display("test interleave and gain done");
    bus(1'b1, dac_ctrl_pkg::ADDR_MODE, 32'h6);
    repeat (2) @(posedge i_clk);
    chk("ref_both", 32'h1, 32'(o_ref_conflict));
    ctrl(8'h58);
    chk("ref_clash", 32'h0, 32'(o_ref_conflict));
    chk("dev_ref_oe", 32'h0, 32'(link.reference_pin_dev_oe));
    chk("host_ref_oe", 32'h1, 32'(link.reference_pin_host_oe));
    bus(1'b1, dac_ctrl_pkg::ADDR_MODE, 32'h4);
    ctrl(8'h48);
    chk("dev_ref_on", 32'h1, 32'(link.reference_pin_dev_oe));
    $display("test reference done");
    ctrl(8'h08);
    wake();
    ctrl(8'hC8);
    chk("pd_valid", 32'h0, 32'(o_outputs_valid));
    wake();
    $display("test power states done");
    bus(1'b1, dac_ctrl_pkg::ADDR_MODE, 32'h5);
    repeat (2) @(posedge i_clk);
    chk("dev_clk_oe", 32'h1, 32'(link.se_clock_dev_oe));
    chk("host_clk_oe", 32'h0, 32'(link.se_clock_host_oe));
    stream(10'h0AB, 10'h1CD);
    bus(1'b1, dac_ctrl_pkg::ADDR_MODE, 32'h4);
    repeat (2) @(posedge i_clk);
    chk("host_clk_back", 32'h1, 32'(link.se_clock_host_oe));
    stream(10'h2D2, 10'h12D);
    $display("test clock modes done");
    summarize();
  end
endmodule // dual_dac_input_and_mode_control_tb
